// ### hw/cph_pkg.sv
// Constants, state encoding and helpers shared by the parameter command handler.
package cph_pkg;

    // ------------------------------------------------------------
    // Command frame codes, flags and lengths
    // ------------------------------------------------------------
    localparam logic [7:0] CPH_CMD_PERIOD  = 8'hA7;
    localparam logic [7:0] CPH_CMD_SHIFT   = 8'hA5;
    localparam logic [7:0] CPH_CMD_COLUMN  = 8'hA9;
    localparam logic [7:0] CPH_LEN_PERIOD  = 8'h03;
    localparam logic [7:0] CPH_LEN_SHIFT   = 8'h01;
    localparam logic [7:0] CPH_LEN_COLUMN  = 8'h02;
    localparam logic [7:0] CPH_LEN_NONE    = 8'h00;
    localparam logic [7:0] CPH_FLAG_WRITE  = 8'h00;
    localparam logic [7:0] CPH_FLAG_READ   = 8'h01;
    localparam logic [7:0] CPH_FLAG_ANSWER = 8'h00;
    localparam logic [2:0] CPH_HDR_TAIL    = 3'h2;   // Flag and length bytes after the code.

    // ------------------------------------------------------------
    // Legal ranges and reset values of the parameters
    // ------------------------------------------------------------
    localparam logic [23:0] CPH_PERIOD_MIN = 24'h000001;
    localparam logic [7:0]  CPH_SHIFT_MAX  = 8'h03;
    localparam logic [15:0] CPH_COLUMN_MAX = 16'h03EF;
    localparam logic [23:0] CPH_PERIOD_RST = 24'h000001;
    localparam logic [1:0]  CPH_SHIFT_RST  = 2'h0;
    localparam logic [9:0]  CPH_COLUMN_RST = 10'h000;
    localparam logic [10:0] CPH_COL_OFFSET = 11'h001;
    localparam logic [7:0]  CPH_MODE_FREE  = 8'h00;
    localparam logic [7:0]  CPH_MODE_RST   = 8'h00;

    // ------------------------------------------------------------
    // Register port map
    // ------------------------------------------------------------
    localparam logic [3:0] CPH_REG_MODE    = 4'h0;
    localparam logic [3:0] CPH_REG_PERIOD  = 4'h4;
    localparam logic [3:0] CPH_REG_SETUP   = 4'h8;
    localparam int         CPH_SETUP_SHIFT = 0;
    localparam int         CPH_SETUP_COL   = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CPH_CLK_PERIOD_NS = 40;
    localparam int CPH_US_NS         = 1000;
    localparam int CPH_CYC_PER_US    = CPH_US_NS / CPH_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Parser states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        CPH_ST_IDLE = 6'h01,
        CPH_ST_FLAG = 6'h02,
        CPH_ST_LEN  = 6'h04,
        CPH_ST_DATA = 6'h08,
        CPH_ST_EXEC = 6'h10,
        CPH_ST_RESP = 6'h20
    } cph_state_e;

    // Expected length of a known command; zero marks an unknown code.
    function automatic logic [7:0] cph_len_for(input logic [7:0] code);
        case (code)
            CPH_CMD_PERIOD: cph_len_for = CPH_LEN_PERIOD;
            CPH_CMD_SHIFT:  cph_len_for = CPH_LEN_SHIFT;
            CPH_CMD_COLUMN: cph_len_for = CPH_LEN_COLUMN;
            default:        cph_len_for = CPH_LEN_NONE;
        endcase
    endfunction

endpackage

// ### hw/cph_pix_if.sv
// Pixel path carrier between the command handler and its shift unit.
`timescale 1ns/1ps
`default_nettype none
interface cph_pix_if #(parameter int PIX_W = 10);
    logic             in_valid;
    logic [PIX_W-1:0] pix_in;
    logic [1:0]       shift;
    logic             out_valid;
    logic [PIX_W-1:0] pix_out;

    modport ctl  (output in_valid, pix_in, shift, input out_valid, pix_out);
    modport unit (input in_valid, pix_in, shift, output out_valid, pix_out);
endinterface
`default_nettype wire

// ### hw/cph_pix_shift.sv
// Digital shift unit that scales pixel values by a power of two.
`timescale 1ns/1ps
`default_nettype none
module cph_pix_shift #(
    parameter int PIX_W = 10
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Pixel path
    cph_pix_if.unit   pix
);
    import cph_pkg::*;

    localparam logic [PIX_W-1:0] PIX_FULL = '1;

    logic             out_valid_ff;
    logic [PIX_W-1:0] pix_out_ff;
    logic [PIX_W+2:0] wide;

    // Shifted value kept wide so overflow can be detected and clipped.
    always_comb begin
        wide = {3'h0, pix.pix_in} << pix.shift;
    end

    // Clip instead of wrapping: a wrapped bright pixel would read dark.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_ff <= 1'b0;
            pix_out_ff   <= '0;
        end else begin
            out_valid_ff <= pix.in_valid;
            pix_out_ff   <= (|wide[PIX_W+2:PIX_W]) ? PIX_FULL : wide[PIX_W-1:0];
        end
    end

    assign pix.out_valid = out_valid_ff;
    assign pix.pix_out   = pix_out_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pix_scale;
        @(posedge ref_clk) disable iff (!rst_b)
        (pix.in_valid && pix.pix_in < (PIX_FULL >> pix.shift))
            |=> pix.pix_out == PIX_W'($past(pix.pix_in) << $past(pix.shift));
    endproperty
    a_pix_scale: assert property (p_pix_scale) else $error("pixel not scaled by shift");

endmodule
`default_nettype wire

// ### hw/cph_top.sv
// Parameter command handler: period timer, digital shift and readout window column.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Period read answered with code, flag zero, three bytes
// - Period write stores value, sends no answer
// - Period bytes arrive low, middle, high
// - Period timer drives triggers only in free run
// - Shift command: one byte, reads answered, writes silent
// - Shift byte zero to three selects shift amount
// - Pixels multiplied by two to shift amount
// - Column command: two bytes, reads answered, writes silent
// - Column bytes arrive low byte first
// - Stored column n means physical column n+1
// - Exposure mode zero is free run with timer
module cph_top #(
    parameter int PIX_W = 10
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // Command bytes from the host receiver
    input  wire logic             rx_valid,
    input  wire logic [7:0]       rx_data,
    output logic                  rx_ready,
    // Answer bytes to the host transmitter
    output logic                  tx_valid,
    output logic [7:0]            tx_data,
    input  wire logic             tx_ready,
    // Register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata,
    // Pixel stream
    input  wire logic             pix_in_valid,
    input  wire logic [PIX_W-1:0] pix_in,
    output logic                  pix_out_valid,
    output logic [PIX_W-1:0]      pix_out,
    // Sensor timing and window
    output logic                  frame_trig,
    output logic [10:0]           win_col_start
);
    import cph_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cph_state_e  state_ff;
    cph_state_e  nxt_state;
    logic [7:0]  code_ff;
    logic [7:0]  flag_ff;
    logic [7:0]  len_ff;
    logic [7:0]  cnt_ff;
    logic [23:0] data_ff;
    logic        rx_ready_ff;
    logic        tx_valid_ff;
    logic [7:0]  tx_data_ff;
    logic [39:0] resp_buf_ff;
    logic [2:0]  resp_left_ff;
    logic [23:0] period_ff;
    logic [1:0]  shift_ff;
    logic [9:0]  col_ff;
    logic [10:0] col_start_ff;
    logic [7:0]  mode_ff;
    logic [31:0] rdata_ff;
    logic [4:0]  us_cnt_ff;
    logic [23:0] per_cnt_ff;
    logic        trig_ff;
    logic        take;
    logic        tx_done;
    logic        is_read;
    logic        len_ok;
    logic        do_read;
    logic        do_write;
    logic        free_run;
    logic        us_tick;
    logic [23:0] rd_value;

    localparam logic [4:0] US_LAST = 5'(CPH_CYC_PER_US - 1);

    cph_pix_if #(.PIX_W(PIX_W)) pix_bus ();

    // ------------------------------------------------------------
    // Frame decode helpers
    // ------------------------------------------------------------
    // A byte is consumed only while the parser advertises room for it.
    assign take     = rx_valid && rx_ready_ff;
    assign tx_done  = tx_valid_ff && tx_ready;
    assign is_read  = (flag_ff == CPH_FLAG_READ);
    assign len_ok   = (len_ff == cph_len_for(code_ff)) && (len_ff != CPH_LEN_NONE);
    assign do_read  = (state_ff == CPH_ST_EXEC) && is_read && len_ok;
    assign do_write = (state_ff == CPH_ST_EXEC) && (flag_ff == CPH_FLAG_WRITE) && len_ok;
    assign free_run = (mode_ff == CPH_MODE_FREE);

    // Current setting of the addressed command, for the answer frame.
    always_comb begin
        case (code_ff)
            CPH_CMD_PERIOD: rd_value = period_ff;
            CPH_CMD_SHIFT:  rd_value = {22'h0, shift_ff};
            CPH_CMD_COLUMN: rd_value = {14'h0, col_ff};
            default:        rd_value = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Parser state machine
    // ------------------------------------------------------------
    // A read frame carries no data even though its length is nonzero.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CPH_ST_IDLE: begin
                if (take) begin
                    nxt_state = CPH_ST_FLAG;
                end
            end
            CPH_ST_FLAG: begin
                if (take) begin
                    nxt_state = CPH_ST_LEN;
                end
            end
            CPH_ST_LEN: begin
                if (take) begin
                    if (is_read || rx_data == CPH_LEN_NONE) begin
                        nxt_state = CPH_ST_EXEC;
                    end else begin
                        nxt_state = CPH_ST_DATA;
                    end
                end
            end
            CPH_ST_DATA: begin
                if (take && (cnt_ff + 8'h01 == len_ff)) begin
                    nxt_state = CPH_ST_EXEC;
                end
            end
            CPH_ST_EXEC: begin
                nxt_state = do_read ? CPH_ST_RESP : CPH_ST_IDLE;
            end
            CPH_ST_RESP: begin
                if (tx_done && resp_left_ff == 3'h0) begin
                    nxt_state = CPH_ST_IDLE;
                end
            end
            default: begin
                nxt_state = CPH_ST_IDLE;
            end
        endcase
    end

    // State register and the registered receive ready.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= CPH_ST_IDLE;
            rx_ready_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            rx_ready_ff <= (nxt_state != CPH_ST_EXEC) && (nxt_state != CPH_ST_RESP);
        end
    end

    // Header capture and data assembly, low byte first.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            code_ff <= '0;
            flag_ff <= '0;
            len_ff  <= '0;
            cnt_ff  <= '0;
            data_ff <= '0;
        end else if (take) begin
            case (state_ff)
                CPH_ST_IDLE: begin
                    code_ff <= rx_data;
                end
                CPH_ST_FLAG: begin
                    flag_ff <= rx_data;
                end
                CPH_ST_LEN: begin
                    len_ff  <= rx_data;
                    cnt_ff  <= '0;
                    data_ff <= '0;
                end
                CPH_ST_DATA: begin
                    // Surplus bytes of an oversized frame are counted and dropped.
                    case (cnt_ff)
                        8'h00:   data_ff[7:0]   <= rx_data;
                        8'h01:   data_ff[15:8]  <= rx_data;
                        8'h02:   data_ff[23:16] <= rx_data;
                        default: data_ff        <= data_ff;
                    endcase
                    cnt_ff <= cnt_ff + 8'h01;
                end
                default: begin
                    cnt_ff <= cnt_ff;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answer frame transmitter
    // ------------------------------------------------------------
    // The code goes out first; the rest waits in a buffer, lowest byte next.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid_ff  <= 1'b0;
            tx_data_ff   <= '0;
            resp_buf_ff  <= '0;
            resp_left_ff <= '0;
        end else if (do_read) begin
            tx_valid_ff  <= 1'b1;
            tx_data_ff   <= code_ff;
            resp_buf_ff  <= {rd_value[23:16], rd_value[15:8], rd_value[7:0],
                             len_ff, CPH_FLAG_ANSWER};
            resp_left_ff <= len_ff[2:0] + CPH_HDR_TAIL;
        end else if (tx_done) begin
            if (resp_left_ff == 3'h0) begin
                tx_valid_ff <= 1'b0;
            end else begin
                tx_data_ff   <= resp_buf_ff[7:0];
                resp_buf_ff  <= resp_buf_ff >> 8;
                resp_left_ff <= resp_left_ff - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Parameter storage
    // ------------------------------------------------------------
    // Writes outside the legal range are dropped so the camera never runs
    // with a zero period or a column past the sensor edge.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            period_ff <= CPH_PERIOD_RST;
            shift_ff  <= CPH_SHIFT_RST;
            col_ff    <= CPH_COLUMN_RST;
        end else if (do_write) begin
            case (code_ff)
                CPH_CMD_PERIOD: begin
                    if (data_ff >= CPH_PERIOD_MIN) begin
                        period_ff <= data_ff;
                    end
                end
                CPH_CMD_SHIFT: begin
                    if (data_ff[7:0] <= CPH_SHIFT_MAX) begin
                        shift_ff <= data_ff[1:0];
                    end
                end
                CPH_CMD_COLUMN: begin
                    if (data_ff[15:0] <= CPH_COLUMN_MAX) begin
                        col_ff <= data_ff[9:0];
                    end
                end
                default: begin
                    period_ff <= period_ff;
                end
            endcase
        end
    end

    // Physical start column is one above the stored setting.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            col_start_ff <= CPH_COL_OFFSET;
        end else begin
            col_start_ff <= {1'b0, col_ff} + CPH_COL_OFFSET;
        end
    end

    // ------------------------------------------------------------
    // Free-run period timer
    // ------------------------------------------------------------
    assign us_tick = (us_cnt_ff == US_LAST);

    // Counters are held clear outside free run so the first period after
    // entering it is complete rather than a leftover fragment.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            us_cnt_ff  <= '0;
            per_cnt_ff <= '0;
            trig_ff    <= 1'b0;
        end else if (!free_run) begin
            us_cnt_ff  <= '0;
            per_cnt_ff <= '0;
            trig_ff    <= 1'b0;
        end else begin
            us_cnt_ff <= us_tick ? 5'h00 : us_cnt_ff + 5'h01;
            trig_ff   <= 1'b0;
            if (us_tick) begin
                if (per_cnt_ff + 24'h000001 >= period_ff) begin
                    per_cnt_ff <= '0;
                    trig_ff    <= 1'b1;
                end else begin
                    per_cnt_ff <= per_cnt_ff + 24'h000001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Exposure mode is software owned; everything else is read only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= CPH_MODE_RST;
        end else if (reg_wr && reg_addr == CPH_REG_MODE) begin
            mode_ff <= reg_wdata[7:0];
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    CPH_REG_MODE:   rdata_ff <= {24'h0, mode_ff};
                    CPH_REG_PERIOD: rdata_ff <= {8'h0, period_ff};
                    CPH_REG_SETUP: begin
                        rdata_ff[CPH_SETUP_SHIFT +: 2] <= shift_ff;
                        rdata_ff[CPH_SETUP_COL +: 10]  <= col_ff;
                    end
                    default:        rdata_ff <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pixel shift unit
    // ------------------------------------------------------------
    assign pix_bus.in_valid = pix_in_valid;
    assign pix_bus.pix_in   = pix_in;
    assign pix_bus.shift    = shift_ff;

    cph_pix_shift #(.PIX_W(PIX_W)) u_shift (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pix     (pix_bus.unit)
    );

    // Outputs, each from a flip-flop.
    assign rx_ready      = rx_ready_ff;
    assign tx_valid      = tx_valid_ff;
    assign tx_data       = tx_data_ff;
    assign reg_rdata     = rdata_ff;
    assign pix_out_valid = pix_bus.out_valid;
    assign pix_out       = pix_bus.pix_out;
    assign frame_trig    = trig_ff;
    assign win_col_start = col_start_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_read_code;
        do_read |=> tx_valid_ff && tx_data_ff == $past(code_ff)
            && resp_buf_ff[7:0] == CPH_FLAG_ANSWER;
    endproperty
    a_read_code: assert property (p_read_code) else $error("answer header wrong");

    property p_write_silent;
        do_write |=> !tx_valid_ff [*2];
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write was answered");

    property p_period_store;
        (do_write && code_ff == CPH_CMD_PERIOD && data_ff != 24'h0)
            |=> period_ff == $past(data_ff);
    endproperty
    a_period_store: assert property (p_period_store) else $error("period not stored");

    property p_period_zero;
        (do_write && code_ff == CPH_CMD_PERIOD && data_ff == 24'h0) |=> $stable(period_ff);
    endproperty
    a_period_zero: assert property (p_period_zero) else $error("zero period taken");

    property p_shift_reject;
        (do_write && code_ff == CPH_CMD_SHIFT && data_ff[7:0] > CPH_SHIFT_MAX)
            |=> $stable(shift_ff);
    endproperty
    a_shift_reject: assert property (p_shift_reject) else $error("bad shift taken");

    property p_col_plus_one;
        $changed(col_ff) |=> win_col_start == {1'b0, $past(col_ff)} + CPH_COL_OFFSET;
    endproperty
    a_col_plus_one: assert property (p_col_plus_one) else $error("column not n+1");

    property p_no_trig_sync;
        !free_run [*2] |-> !frame_trig;
    endproperty
    a_no_trig_sync: assert property (p_no_trig_sync) else $error("trigger outside free run");

    property p_col_readback;
        (do_read && code_ff == CPH_CMD_COLUMN)
            |=> resp_buf_ff[23:16] == $past(col_ff[7:0]) && resp_buf_ff[31:24] == 8'(col_ff[9:8]);
    endproperty
    a_col_readback: assert property (p_col_readback) else $error("column read mismatch");

    c_period_read: cover property (do_read && code_ff == CPH_CMD_PERIOD);
    c_shift_write: cover property (do_write && code_ff == CPH_CMD_SHIFT);
    c_column_write: cover property (do_write && code_ff == CPH_CMD_COLUMN);
    c_trigger: cover property (frame_trig);

endmodule
`default_nettype wire

// ### tb/cph_host.sv
// Host model that sends command frames and collects answer bytes.
`timescale 1ns/1ps
`default_nettype none
module cph_host (
    // Clock
    input  wire logic       ref_clk,
    // Command bytes
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    // Answer bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] ans_q[$];
    bit         slow = 0;
    int         stalls = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
    end
    // A slow host takes answer bytes only every other cycle.
    always @(posedge ref_clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready)
            ans_q.push_back(tx_data);
    end
    // Sends code, flag, length and nd data bytes, low byte first.
    task automatic frame(logic [7:0] c, f, l, logic [23:0] v, int nd);
        logic [47:0] b = {v, l, f, c};
        int          n = 0;
        rx_valid <= 1'b1;
        for (int i = 0; i < 3 + nd; i++) begin
            rx_data <= b[8*i+:8];
            do begin
                n++;
                @(posedge ref_clk);
            end while (rx_ready !== 1'b1 && n < 500);
        end
        if (n >= 500) stalls++; // A byte never taken counts against the run.
        rx_valid <= 1'b0;
        rx_data  <= ~b[8*(2+nd)+:8]; // Idle data is inverted so it never looks stale.
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/test_cph_top.sv
// Testbench for the parameter command handler.
`timescale 1ns/1ps
`default_nettype none
module test_cph_top;
    import cph_pkg::*;
    logic        ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, pv = 0;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, pov, trig;
    logic [7:0]  rx_data, tx_data;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, q;
    logic [9:0]  pin = 0, pout;
    logic [10:0] col;
    int          n_fail = 0, cmp_count = 0;
    cph_top DUT (.ref_clk, .rst_b, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
        .tx_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_in_valid(pv),
        .pix_in(pin), .pix_out_valid(pov), .pix_out(pout), .frame_trig(trig), .win_col_start(col));
    cph_host host (.ref_clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);
    initial forever #20 ref_clk = ~ref_clk;
    // ----
    // Shared tasks
    // ----
    task automatic chk(string nm, logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(logic [3:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        q = reg_rdata;
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Answers are compared byte by byte against code, zero flag, length and data.
    task automatic ans(logic [7:0] c, l, logic [23:0] v);
        logic [47:0] e = {v, l, CPH_FLAG_ANSWER, c};
        int          n = 0;
        while (host.ans_q.size() < 3 + l && n < 200) begin
            n++;
            @(posedge ref_clk);
        end
        for (int i = 0; i < 3 + l; i++)
            chk("answer", e[8*i+:8], host.ans_q[i]);
        host.ans_q.delete();
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_period;
        rd(CPH_REG_PERIOD);
        chk("period_rst", 32'h1, q);
        chk("col_rst", 32'h1, col);
        host.slow = 1;
        host.frame(CPH_CMD_PERIOD, 8'h00, 8'h03, 24'h123456, 3);
        repeat (10) @(posedge ref_clk);
        chk("no_answer", 0, host.ans_q.size());
        host.frame(CPH_CMD_PERIOD, 8'h00, 8'h03, 24'h0, 3);
        host.frame(CPH_CMD_PERIOD, 8'h01, 8'h03, 24'h0, 0);
        ans(CPH_CMD_PERIOD, 8'h03, 24'h123456);
        host.slow = 0;
        $display("test period done");
    endtask
    task automatic t_shift;
        int s;
        for (int k = 0; k < 5; k++) begin
            host.frame(CPH_CMD_SHIFT, 8'h00, 8'h01, k, 1);
            repeat (3) @(posedge ref_clk);
            s = (k < 4) ? k : 3;
            pv  <= 1'b1;
            pin <= 10'h0A5;
            @(posedge ref_clk);
            pv <= 1'b0;
            @(posedge ref_clk);
            chk("pix_valid", 1, pov);
            chk("pix", ((32'hA5 << s) > 32'h3FF) ? 32'h3FF : (32'hA5 << s), pout);
        end
        host.frame(CPH_CMD_SHIFT, 8'h02, 8'h01, 24'h1, 1);
        host.frame(CPH_CMD_SHIFT, 8'h01, 8'h02, 24'h0, 0);
        host.frame(CPH_CMD_SHIFT, 8'h01, 8'h01, 24'h0, 0);
        ans(CPH_CMD_SHIFT, 8'h01, 24'h3);
        $display("test shift done");
    endtask
    task automatic t_column;
        host.frame(CPH_CMD_COLUMN, 8'h00, 8'h02, 24'd99, 2);
        repeat (3) @(posedge ref_clk);
        chk("col_99", 11'd100, col);
        host.frame(CPH_CMD_COLUMN, 8'h00, 8'h02, 24'h3EF, 2);
        host.frame(CPH_CMD_COLUMN, 8'h00, 8'h02, 24'h3F0, 2);
        host.frame(CPH_CMD_COLUMN, 8'h00, 8'h03, 24'h001, 3);
        repeat (3) @(posedge ref_clk);
        chk("col_max", 11'h3F0, col);
        rd(CPH_REG_SETUP);
        chk("setup", (32'h3EF << CPH_SETUP_COL) | (32'h3 << CPH_SETUP_SHIFT), q);
        host.frame(CPH_CMD_COLUMN, 8'h01, 8'h02, 24'h0, 0);
        ans(CPH_CMD_COLUMN, 8'h02, 24'h3EF);
        $display("test column done");
    endtask
    task automatic t_timer;
        int n = 0;
        host.frame(CPH_CMD_PERIOD, 8'h00, 8'h03, 24'h2, 3);
        repeat (60) @(posedge ref_clk);
        while (trig !== 1'b1 && n < 300) begin
            n++;
            @(posedge ref_clk);
        end
        n = 0;
        do begin
            n++;
            @(posedge ref_clk);
        end while (trig !== 1'b1 && n < 300);
        chk("trig_gap", 2 * CPH_CYC_PER_US, n);
        wr(CPH_REG_MODE, 32'h1);
        n = 0;
        repeat (120) begin
            @(posedge ref_clk);
            n += (trig === 1'b1);
        end
        chk("trig_held", 0, n);
        rd(CPH_REG_MODE);
        chk("mode_rd", 32'h1, q);
        rd(4'hC);
        chk("unmapped", 32'h0, q);
        $display("test timer done");
    endtask
    task automatic summarize;
        chk("host_stall", 0, host.stalls);
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // The whole run needs under two thousand cycles; the watchdog allows ten times that.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        summarize;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_period;
        t_shift;
        t_column;
        t_timer;
        summarize;
    end
endmodule
`default_nettype wire
